// >>> verilog/bus_resp_map.svh
`ifndef BUS_RESP_MAP_SVH
`define BUS_RESP_MAP_SVH

// Acknowledge codes on {ack1_n, ack0_n}
`define ACK_NONE 2'h3
`define ACK_32 2'h0
`define ACK_16 2'h1
`define ACK_8 2'h2

// Byte count field, zero meaning four bytes
`define SIZE_FOUR 2'h0

// CPU space cycle decode
`define SPACE_CPU 3'h7
`define CPU_TYPE_LSB 16
`define CPU_TYPE_IACK 4'hF

// Responder shape
`define PORT_BYTES 4
`define WAIT_STATES 4'h1
`define MEM_DEPTH 256
`define MEM_BASE 32'h00000000

`endif

// >>> verilog/bus_resp_pkg.sv
package bus_resp_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_DECODE = 3'h1,
		ST_WAIT = 3'h3,
		ST_ACK = 3'h2,
		ST_RELEASE = 3'h6
	} cycle_state_t;

	typedef enum logic [1:0] {
		ARB_IDLE = 2'h0,
		ARB_REQ = 2'h1,
		ARB_OWN = 2'h3
	} arb_state_t;

endpackage

// >>> verilog/resp_link_if.sv
`timescale 1ns/1ns
interface resp_link_if;
	logic [1:0] addr_low;
	logic [1:0] size;
	logic [31:0] wr_data;
	logic [31:0] mem_word;
	logic [31:0] rd_data;
	logic [31:0] merged_word;
	logic want;
	logic grant_n;
	logic as_n;
	logic req_n;
	logic taken_n;

	modport top_side (
		output addr_low, size, wr_data, mem_word, want, grant_n, as_n,
		input rd_data, merged_word, req_n, taken_n
	);
	modport lane (
		input addr_low, size, wr_data, mem_word,
		output rd_data, merged_word
	);
	modport arb (
		input want, grant_n, as_n,
		output req_n, taken_n
	);
endinterface

// >>> verilog/byte_lane_steer.sv
`timescale 1ns/1ns
`include "bus_resp_map.svh"
module byte_lane_steer #(
	parameter int PORT_BYTES = `PORT_BYTES
) (
	resp_link_if.lane lk
);
	logic [2:0] count;
	logic [2:0] first;
	logic [2:0] last;
	logic [2:0] port_first;
	logic [2:0] port_last;

	// Bytes still to move: one to four
	assign count = (lk.size == `SIZE_FOUR) ? 3'h4 : {1'b0, lk.size}; // RULE2
	assign first = {1'b0, lk.addr_low};
	assign last = first + count - 3'h1;
	// Narrow ports sit on the upper lanes
	assign port_first = (PORT_BYTES == 4) ? 3'h0 :
		(PORT_BYTES == 2) ? {1'b0, lk.addr_low[1], 1'b0} : first; // RULE13
	assign port_last = port_first + 3'(PORT_BYTES - 1);

	genvar j;
	generate
		for (j = 0; j < 4; j++) begin : g_byte
			localparam logic [2:0] J = 3'(j);
			wire active;
			wire [1:0] lane;
			wire [2:0] src;
			assign active = J >= first && J <= last &&
				J >= port_first && J <= port_last; // RULE2
			assign lane = 2'(J - port_first);
			assign src = port_first + J;
			assign lk.merged_word[31 - 8 * j -: 8] = active ?
				lk.wr_data[8 * (3 - lane) +: 8] :
				lk.mem_word[31 - 8 * j -: 8];
			assign lk.rd_data[31 - 8 * j -: 8] =
				(J < 3'(PORT_BYTES) && src <= 3'h3) ?
				lk.mem_word[8 * (3 - src[1:0]) +: 8] : 8'h00; // RULE13
		end
	endgenerate
endmodule

// >>> verilog/mastership_arbiter.sv
`timescale 1ns/1ns
module mastership_arbiter (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	resp_link_if.arb lk
);
	bus_resp_pkg::arb_state_t state;
	bus_resp_pkg::arb_state_t next_state;
	wire can_take;

	// Take over only once granted and the current cycle has ended
	assign can_take = !lk.grant_n && lk.as_n; // RULE20

	always_comb begin
		next_state = state;
		case (state)
			bus_resp_pkg::ARB_IDLE: begin
				if (lk.want)
					next_state = bus_resp_pkg::ARB_REQ;
			end
			bus_resp_pkg::ARB_REQ: begin
				if (!lk.want)
					next_state = bus_resp_pkg::ARB_IDLE;
				else if (can_take)
					next_state = bus_resp_pkg::ARB_OWN;
			end
			bus_resp_pkg::ARB_OWN: begin
				if (!lk.want)
					next_state = bus_resp_pkg::ARB_IDLE;
			end
			default: next_state = bus_resp_pkg::ARB_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= bus_resp_pkg::ARB_IDLE;
			lk.req_n <= 1'b1;
			lk.taken_n <= 1'b1;
		end else if (ce) begin
			state <= next_state;
			lk.req_n <= next_state != bus_resp_pkg::ARB_REQ; // RULE18
			lk.taken_n <= next_state != bus_resp_pkg::ARB_OWN; // RULE20
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	request_on_want_a: assert property ( // RULE18
		(ce && lk.want && state == bus_resp_pkg::ARB_IDLE) |=> !lk.req_n)
		else $error("bus request not raised for pending want");
	take_after_grant_a: assert property ( // RULE20
		$fell(lk.taken_n) |-> $past(!lk.grant_n && lk.as_n && lk.want))
		else $error("bus taken without grant or during a cycle");
endmodule

// >>> verilog/bus_responder.sv
`timescale 1ns/1ns
`include "bus_resp_map.svh"
// Contract
// RULE1 - Processor drives a 32-bit byte address on each cycle.
// RULE2 - A cycle moves one to four bytes over the 32-bit data path.
// RULE3 - Processor outputs a 3-bit address space code each cycle.
// RULE4 - Byte count field and low address bits select active lanes.
// RULE5 - Processor marks indivisible read-modify-write cycles as locked.
// RULE6 - Processor flags the start of every bus cycle.
// RULE7 - Operand start flag appears only on an operand's first cycle.
// RULE8 - Address strobe asserted only while the address is valid.
// RULE9 - Data strobe marks when read data is due or write data present.
// RULE10 - Processor drives read or write direction for each transfer.
// RULE11 - Processor provides an enable for external data buffers.
// RULE12 - Responder drives the acknowledge pair when the transfer completes.
// RULE13 - Acknowledge pair also reports the responding port width.
// RULE14 - Processor stops using its instruction cache while inhibited.
// RULE15 - Interrupt logic presents an encoded level on three lines.
// RULE16 - In interrupt acknowledge, responder may request an autovector.
// RULE17 - Processor signals when an interrupt is pending internally.
// RULE18 - An external master wanting the bus asserts bus request.
// RULE19 - Processor asserts bus grant to let the master take over.
// RULE20 - External master asserts grant taken once it owns the bus.
// RULE21 - Asserting halt suspends processor bus activity.
// RULE22 - Bus fault input asserted for invalid or illegal operations.
// RULE23 - Processor holds each cycle stable until acknowledge or fault.
module bus_responder #(
	parameter int PORT_BYTES = `PORT_BYTES,
	parameter int MEM_DEPTH = `MEM_DEPTH,
	parameter logic [3:0] WAIT_STATES = `WAIT_STATES,
	parameter logic [31:0] MEM_BASE = `MEM_BASE
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [31:0] proc_addr,
	input wire logic [2:0] addr_space_code,
	input wire logic [1:0] xfer_bytes_left,
	input wire logic locked_cycle_ind_n,
	input wire logic ext_cycle_start_n,
	input wire logic oper_cycle_start_n,
	input wire logic addr_strobe_n,
	input wire logic data_strobe_n,
	input wire logic read_not_write,
	input wire logic buffer_enable_n,
	input wire logic [31:0] proc_data_in,
	input wire logic irq_pending_n,
	input wire logic bus_grant_n,
	input wire logic [2:0] irq_req_level,
	input wire logic irq_use_autovec,
	input wire logic [7:0] irq_vector,
	input wire logic halt_req,
	input wire logic cache_off,
	input wire logic dma_want,
	output logic [31:0] proc_data_out,
	output logic proc_data_oe_n,
	output logic [1:0] xfer_ack_size_n,
	output logic bus_fault_n,
	output logic auto_vector_req_n,
	output logic [2:0] irq_level_n,
	output logic halt_n,
	output logic cache_inhibit_n,
	output logic bus_req_n,
	output logic bus_grant_taken_n,
	output logic dma_owns,
	output logic irq_pending_seen,
	output logic cycle_done,
	output logic locked_seen
);
	localparam int IDX_W = $clog2(MEM_DEPTH);
	localparam logic [1:0] PORT_ACK = (PORT_BYTES == 4) ? `ACK_32 :
		(PORT_BYTES == 2) ? `ACK_16 : `ACK_8;

	bus_resp_pkg::cycle_state_t state;
	bus_resp_pkg::cycle_state_t next_state;
	logic [31:0] mem [0:MEM_DEPTH-1];
	logic [31:0] cap_addr;
	logic [1:0] cap_size;
	logic cap_read;
	logic cap_iack;
	logic [3:0] wait_cnt;
	logic owns_q;

	resp_link_if lk();

	////////////////////////////////////////////////////////////////////
	// Decode

	wire start_cycle;
	wire is_iack;
	wire in_range;
	wire iack_match;
	wire cap_fault;
	wire respond;
	wire do_write;
	wire [IDX_W-1:0] word_idx;

	// Serve processor cycles only while no other master owns the bus
	assign start_cycle = state == bus_resp_pkg::ST_IDLE &&
		!addr_strobe_n && !owns_q;
	assign is_iack = addr_space_code == `SPACE_CPU &&
		proc_addr[`CPU_TYPE_LSB +: 4] == `CPU_TYPE_IACK;
	assign in_range = (cap_addr >> (IDX_W + 2)) ==
		(MEM_BASE >> (IDX_W + 2));
	// Level being acknowledged must match the level presented
	assign iack_match = cap_addr[3:1] == irq_req_level;
	assign cap_fault = cap_iack ? !iack_match : !in_range; // RULE22
	assign respond = state == bus_resp_pkg::ST_WAIT &&
		wait_cnt == 4'h0 && !data_strobe_n && !addr_strobe_n; // RULE9
	assign do_write = respond && !cap_read && !cap_fault && !cap_iack;
	assign word_idx = cap_addr[IDX_W+1:2];

	assign lk.addr_low = cap_addr[1:0];
	assign lk.size = cap_size;
	assign lk.wr_data = proc_data_in;
	assign lk.mem_word = mem[word_idx];
	assign lk.want = dma_want;
	assign lk.grant_n = bus_grant_n;
	assign lk.as_n = addr_strobe_n;
	assign bus_req_n = lk.req_n;
	assign bus_grant_taken_n = lk.taken_n;

	byte_lane_steer #(
		.PORT_BYTES(PORT_BYTES)
	) u_lanes (
		.lk(lk)
	);

	mastership_arbiter u_arb (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.lk(lk)
	);

	////////////////////////////////////////////////////////////////////
	// Cycle sequencer

	always_comb begin
		next_state = state;
		case (state)
			bus_resp_pkg::ST_IDLE: begin
				if (start_cycle)
					next_state = bus_resp_pkg::ST_DECODE;
			end
			bus_resp_pkg::ST_DECODE: begin
				next_state = bus_resp_pkg::ST_WAIT;
			end
			bus_resp_pkg::ST_WAIT: begin
				if (addr_strobe_n)
					next_state = bus_resp_pkg::ST_RELEASE;
				else if (respond)
					next_state = bus_resp_pkg::ST_ACK;
			end
			bus_resp_pkg::ST_ACK: begin
				if (addr_strobe_n)
					next_state = bus_resp_pkg::ST_RELEASE;
			end
			bus_resp_pkg::ST_RELEASE: begin
				next_state = bus_resp_pkg::ST_IDLE;
			end
			default: next_state = bus_resp_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			state <= bus_resp_pkg::ST_IDLE;
		else if (ce)
			state <= next_state;
	end

	// Cycle attributes held from address strobe onward
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cap_addr <= 32'h00000000;
			cap_size <= `SIZE_FOUR;
			cap_read <= 1'b1;
			cap_iack <= 1'b0;
		end else if (ce && start_cycle) begin
			cap_addr <= proc_addr;
			cap_size <= xfer_bytes_left;
			cap_read <= read_not_write;
			cap_iack <= is_iack;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			wait_cnt <= 4'h0;
		else if (ce && state == bus_resp_pkg::ST_DECODE)
			wait_cnt <= WAIT_STATES;
		else if (ce && wait_cnt != 4'h0)
			wait_cnt <= wait_cnt - 4'h1;
	end

	always_ff @(posedge core_clk) begin
		if (ce && do_write)
			mem[word_idx] <= lk.merged_word;
	end

	////////////////////////////////////////////////////////////////////
	// Responses

	wire [1:0] ack_code;
	wire [31:0] read_value;
	wire drive_data;
	wire use_autovec;
	wire end_resp;

	assign use_autovec = cap_iack && irq_use_autovec;
	// Vector goes out as a byte on the top lane
	assign ack_code = cap_iack ? `ACK_8 : PORT_ACK; // RULE13
	assign read_value = cap_iack ? {irq_vector, 24'h000000} : lk.rd_data;
	assign drive_data = cap_read && !use_autovec;
	assign end_resp = next_state == bus_resp_pkg::ST_RELEASE;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			xfer_ack_size_n <= `ACK_NONE;
			bus_fault_n <= 1'b1;
			auto_vector_req_n <= 1'b1;
		end else if (ce && end_resp) begin
			xfer_ack_size_n <= `ACK_NONE;
			bus_fault_n <= 1'b1;
			auto_vector_req_n <= 1'b1;
		end else if (ce && respond) begin
			if (cap_fault)
				bus_fault_n <= 1'b0; // RULE22
			else if (use_autovec)
				auto_vector_req_n <= 1'b0; // RULE16
			else
				xfer_ack_size_n <= ack_code; // RULE12
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			proc_data_out <= 32'h00000000;
			proc_data_oe_n <= 1'b1;
		end else if (ce && end_resp) begin
			proc_data_oe_n <= 1'b1;
		end else if (ce && respond && !cap_fault && drive_data) begin
			proc_data_out <= read_value; // RULE9
			proc_data_oe_n <= 1'b0;
		end
	end

	// Sideband levels toward the processor and registered status flags
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_level_n <= 3'h7;
			halt_n <= 1'b1;
			cache_inhibit_n <= 1'b1;
			irq_pending_seen <= 1'b0;
			locked_seen <= 1'b0;
			dma_owns <= 1'b0;
			owns_q <= 1'b0;
			cycle_done <= 1'b0;
		end else if (ce) begin
			irq_level_n <= ~irq_req_level; // RULE15
			halt_n <= !halt_req; // RULE21
			cache_inhibit_n <= !cache_off;
			irq_pending_seen <= !irq_pending_n;
			locked_seen <= !locked_cycle_ind_n && !addr_strobe_n;
			dma_owns <= !lk.taken_n;
			owns_q <= !lk.taken_n;
			cycle_done <= respond;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	ack_after_strobe_a: assert property ( // RULE9
		$changed(xfer_ack_size_n) && xfer_ack_size_n != `ACK_NONE
		|-> $past(!data_strobe_n && !addr_strobe_n))
		else $error("acknowledge given before data strobe");
	ack_until_release_a: assert property ( // RULE12
		xfer_ack_size_n != `ACK_NONE && !addr_strobe_n
		|=> xfer_ack_size_n != `ACK_NONE)
		else $error("acknowledge dropped while cycle still open");
	ack_port_width_a: assert property ( // RULE13
		xfer_ack_size_n != `ACK_NONE
		|-> xfer_ack_size_n == (cap_iack ? `ACK_8 : PORT_ACK))
		else $error("acknowledge reports wrong port width");
	fault_excludes_ack_a: assert property ( // RULE22
		!bus_fault_n |-> xfer_ack_size_n == `ACK_NONE &&
		auto_vector_req_n && proc_data_oe_n)
		else $error("fault asserted together with a normal answer");
	fault_cause_a: assert property ( // RULE22
		$fell(bus_fault_n) |-> cap_fault && $past(state) ==
		bus_resp_pkg::ST_WAIT)
		else $error("bus fault without an invalid access");
	autovec_only_iack_a: assert property ( // RULE16
		$fell(auto_vector_req_n) |-> cap_iack && irq_use_autovec)
		else $error("autovector request outside interrupt acknowledge");
	level_follows_a: assert property ( // RULE15
		ce |=> irq_level_n == ~$past(irq_req_level))
		else $error("interrupt level lines not updated");
	halt_follows_a: assert property ( // RULE21
		ce |=> halt_n == !$past(halt_req))
		else $error("halt line does not follow request");
	drive_only_read_a: assert property ( // RULE2
		!proc_data_oe_n |-> cap_read && $past(!addr_strobe_n) ##1
		(proc_data_oe_n || !$past(addr_strobe_n)))
		else $error("data driven outside a read cycle");
endmodule

// >>> bench/cpu_bus_model.sv
`timescale 1ns/1ns
module cpu_bus_model (
	input wire logic core_clk,
	input wire logic [31:0] proc_data_out,
	input wire logic [1:0] xfer_ack_size_n,
	input wire logic bus_fault_n,
	input wire logic auto_vector_req_n,
	input wire logic [2:0] irq_level_n,
	input wire logic halt_n,
	input wire logic cache_inhibit_n,
	input wire logic bus_req_n,
	output logic [31:0] proc_addr,
	output logic [2:0] addr_space_code,
	output logic [1:0] xfer_bytes_left,
	output logic locked_cycle_ind_n,
	output logic ext_cycle_start_n,
	output logic oper_cycle_start_n,
	output logic addr_strobe_n,
	output logic data_strobe_n,
	output logic read_not_write,
	output logic buffer_enable_n,
	output logic [31:0] proc_data_in,
	output logic irq_pending_n,
	output logic bus_grant_n
);
	initial begin
		proc_addr = 32'h0;
		addr_space_code = 3'h0;
		xfer_bytes_left = 2'h0;
		locked_cycle_ind_n = 1'b1;
		ext_cycle_start_n = 1'b1;
		oper_cycle_start_n = 1'b1;
		addr_strobe_n = 1'b1;
		data_strobe_n = 1'b1;
		read_not_write = 1'b1;
		buffer_enable_n = 1'b1;
		proc_data_in = 32'h0;
		irq_pending_n = 1'b1;
		bus_grant_n = 1'b1;
	end

	always @(negedge core_clk) begin
		irq_pending_n <= (irq_level_n === 3'h7);
		bus_grant_n <= !(bus_req_n === 1'b0 && addr_strobe_n);
	end

	task automatic cyc(input logic [31:0] a, input logic [2:0] fc,
		input logic [1:0] sz, input logic rnw, input logic lk,
		input logic [31:0] wd, output logic [31:0] rd,
		output logic [1:0] ack, output logic flt, output logic av,
		output logic tmo, output int lat);
		int n;
		for (n = 0; n < 50 && halt_n !== 1'b1; n++) begin
			@(negedge core_clk);
		end
		@(negedge core_clk);
		proc_addr <= a;
		addr_space_code <= fc;
		xfer_bytes_left <= sz;
		read_not_write <= rnw;
		locked_cycle_ind_n <= ~lk;
		ext_cycle_start_n <= 1'b0;
		oper_cycle_start_n <= 1'b0;
		@(negedge core_clk);
		ext_cycle_start_n <= 1'b1;
		oper_cycle_start_n <= 1'b1;
		addr_strobe_n <= 1'b0;
		data_strobe_n <= 1'b0;
		buffer_enable_n <= 1'b0;
		if (!rnw) proc_data_in <= wd;
		tmo = 1'b1;
		for (n = 0; n < 40 && tmo; n++) begin
			@(negedge core_clk);
			if (xfer_ack_size_n !== 2'h3 || bus_fault_n !== 1'b1 ||
				auto_vector_req_n !== 1'b1) tmo = 1'b0;
		end
		lat = n;
		rd = proc_data_out;
		ack = xfer_ack_size_n;
		flt = bus_fault_n;
		av = auto_vector_req_n;
		@(negedge core_clk);
		addr_strobe_n <= 1'b1;
		data_strobe_n <= 1'b1;
		buffer_enable_n <= 1'b1;
		locked_cycle_ind_n <= 1'b1;
		// Released lines no longer show the old value
		proc_addr <= ~proc_addr;
		proc_data_in <= ~proc_data_in;
		repeat (3) @(negedge core_clk);
	endtask
endmodule

// >>> bench/tb_bus_responder.sv
`timescale 1ns/1ns
`include "bus_resp_map.svh"
module tb_bus_responder;
	logic core_clk, rst, ce, locked_cycle_ind_n, ext_cycle_start_n;
	logic oper_cycle_start_n, addr_strobe_n, data_strobe_n;
	logic read_not_write, buffer_enable_n, irq_pending_n, bus_grant_n;
	logic irq_use_autovec, halt_req, cache_off, dma_want;
	logic proc_data_oe_n, bus_fault_n, auto_vector_req_n, halt_n;
	logic cache_inhibit_n, bus_req_n, bus_grant_taken_n, dma_owns;
	logic irq_pending_seen, cycle_done, locked_seen, flt, av, tmo;
	logic [31:0] proc_addr, proc_data_in, proc_data_out, rdata;
	logic [2:0] addr_space_code, irq_req_level, irq_level_n;
	logic [1:0] xfer_bytes_left, xfer_ack_size_n, ack;
	logic [7:0] irq_vector;
	int err_count = 0;
	int n_checks = 0;
	int done_cnt = 0;
	int lat;
	logic lock_hit = 1'b0;

	bus_responder i_dut (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.proc_addr(proc_addr),
		.addr_space_code(addr_space_code),
		.xfer_bytes_left(xfer_bytes_left),
		.locked_cycle_ind_n(locked_cycle_ind_n),
		.ext_cycle_start_n(ext_cycle_start_n),
		.oper_cycle_start_n(oper_cycle_start_n),
		.addr_strobe_n(addr_strobe_n),
		.data_strobe_n(data_strobe_n),
		.read_not_write(read_not_write),
		.buffer_enable_n(buffer_enable_n),
		.proc_data_in(proc_data_in),
		.irq_pending_n(irq_pending_n),
		.bus_grant_n(bus_grant_n),
		.irq_req_level(irq_req_level),
		.irq_use_autovec(irq_use_autovec),
		.irq_vector(irq_vector),
		.halt_req(halt_req),
		.cache_off(cache_off),
		.dma_want(dma_want),
		.proc_data_out(proc_data_out),
		.proc_data_oe_n(proc_data_oe_n),
		.xfer_ack_size_n(xfer_ack_size_n),
		.bus_fault_n(bus_fault_n),
		.auto_vector_req_n(auto_vector_req_n),
		.irq_level_n(irq_level_n),
		.halt_n(halt_n),
		.cache_inhibit_n(cache_inhibit_n),
		.bus_req_n(bus_req_n),
		.bus_grant_taken_n(bus_grant_taken_n),
		.dma_owns(dma_owns),
		.irq_pending_seen(irq_pending_seen),
		.cycle_done(cycle_done),
		.locked_seen(locked_seen)
	);
	cpu_bus_model i_cpu (
		.core_clk(core_clk),
		.proc_data_out(proc_data_out),
		.xfer_ack_size_n(xfer_ack_size_n),
		.bus_fault_n(bus_fault_n),
		.auto_vector_req_n(auto_vector_req_n),
		.irq_level_n(irq_level_n),
		.halt_n(halt_n),
		.cache_inhibit_n(cache_inhibit_n),
		.bus_req_n(bus_req_n),
		.proc_addr(proc_addr),
		.addr_space_code(addr_space_code),
		.xfer_bytes_left(xfer_bytes_left),
		.locked_cycle_ind_n(locked_cycle_ind_n),
		.ext_cycle_start_n(ext_cycle_start_n),
		.oper_cycle_start_n(oper_cycle_start_n),
		.addr_strobe_n(addr_strobe_n),
		.data_strobe_n(data_strobe_n),
		.read_not_write(read_not_write),
		.buffer_enable_n(buffer_enable_n),
		.proc_data_in(proc_data_in),
		.irq_pending_n(irq_pending_n),
		.bus_grant_n(bus_grant_n)
	);

	// Pulses and lock marks seen between checks
	always @(negedge core_clk) begin
		if (cycle_done === 1'b1)
			done_cnt++;
		if (locked_seen === 1'b1)
			lock_hit = 1'b1;
	end

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic results();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic access(input logic [31:0] a, input logic [2:0] fc,
		input logic [1:0] sz, input logic rnw, input logic [31:0] wd);
		int d0;
		d0 = done_cnt;
		i_cpu.cyc(a, fc, sz, rnw, 1'b0, wd, rdata, ack, flt, av, tmo,
			lat);
		if (tmo) begin
			err_count++;
			$display("BAD answer expected 1 seen 0");
			results();
		end else begin
			chk("ack idle", 32'h3, {30'h0, xfer_ack_size_n});
			chk("bus freed", 32'h1, {31'h0, proc_data_oe_n});
			chk("done pulse", 32'h1, done_cnt - d0);
			chk("latency", `WAIT_STATES + 32'h3, lat);
		end
	endtask

	task automatic t_lock();
		lock_hit = 1'b0;
		i_cpu.cyc(32'h10, 3'h5, 2'h0, 1'b1, 1'b1, 32'h0, rdata, ack, flt,
			av, tmo, lat);
		chk("locked", 32'h1, {31'h0, lock_hit});
		chk("locked data", 32'h11AAEEFF, rdata);
		lock_hit = 1'b0;
		rd_chk(32'h10, 32'h11AAEEFF);
		chk("unlocked", 32'h0, {31'h0, lock_hit});
	endtask

	task automatic t_freeze();
		@(negedge core_clk);
		ce = 1'b0;
		halt_req = 1'b1;
		repeat (3) @(negedge core_clk);
		chk("frozen", 32'h1, {31'h0, halt_n});
		ce = 1'b1;
		repeat (2) @(negedge core_clk);
		chk("unfrozen", 32'h0, {31'h0, halt_n});
		halt_req = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask

	task automatic wr(input logic [31:0] a, input logic [1:0] sz,
		input logic [31:0] wd);
		access(a, 3'h1, sz, 1'b0, wd);
		chk("write ack", {30'h0, `ACK_32}, {30'h0, ack});
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		access(a, 3'h1, 2'h0, 1'b1, 32'h0);
		chk("read ack", {30'h0, `ACK_32}, {30'h0, ack});
		chk("read data", exp, rdata);
	endtask

	task automatic t_reset();
		chk("reset outs", 32'h3FFC, {18'h0, xfer_ack_size_n, bus_fault_n,
			auto_vector_req_n, proc_data_oe_n, irq_level_n, halt_n,
			cache_inhibit_n, bus_req_n, bus_grant_taken_n, dma_owns,
			cycle_done});
		chk("reset data", 32'h0, proc_data_out);
	endtask

	task automatic t_lanes();
		wr(32'h10, 2'h0, 32'h11223344);
		wr(32'h11, 2'h1, 32'h55AA5555);
		wr(32'h12, 2'h2, 32'h7777EEFF);
		rd_chk(32'h10, 32'h11AAEEFF);
		wr(32'h20, 2'h0, 32'h01020304);
		wr(32'h21, 2'h3, 32'hEEBBCCDD);
		rd_chk(32'h20, 32'h01BBCCDD);
	endtask

	task automatic t_edge();
		wr(32'h3FC, 2'h0, 32'hCAFEF00D);
		rd_chk(32'h3FC, 32'hCAFEF00D);
		access(32'h400, 3'h1, 2'h0, 1'b0, 32'h0);
		chk("fault", 32'h0, {31'h0, flt});
		chk("fault ack", 32'h3, {30'h0, ack});
	endtask

	task automatic t_iack();
		@(negedge core_clk);
		irq_req_level = 3'h5;
		access(32'h000F000A, 3'h7, 2'h1, 1'b1, 32'h0);
		chk("iack ack", {30'h0, `ACK_8}, {30'h0, ack});
		chk("vector", 32'hA7, {24'h0, rdata[31:24]});
		@(negedge core_clk);
		irq_use_autovec = 1'b1;
		access(32'h000F000A, 3'h7, 2'h1, 1'b1, 32'h0);
		chk("autovector", 32'h0, {31'h0, av});
		chk("autovec ack", 32'h3, {30'h0, ack});
		access(32'h000F0006, 3'h7, 2'h1, 1'b1, 32'h0);
		chk("level fault", 32'h0, {31'h0, flt});
	endtask

	task automatic t_side();
		for (int i = 0; i < 8; i++) begin
			@(negedge core_clk);
			irq_req_level = i[2:0];
			halt_req = i[0];
			cache_off = i[1];
			repeat (3) @(negedge core_clk);
			chk("level", {29'h0, ~i[2:0]}, {29'h0, irq_level_n});
			chk("halt", {31'h0, ~i[0]}, {31'h0, halt_n});
			chk("cache", {31'h0, ~i[1]}, {31'h0, cache_inhibit_n});
			chk("irq_pending_n", {31'h0, i != 0}, {31'h0, irq_pending_seen});
		end
		irq_req_level = 3'h0;
		halt_req = 1'b0;
		cache_off = 1'b0;
		repeat (3) @(negedge core_clk);
	endtask

	task automatic t_arb();
		int d0;
		dma_want = 1'b1;
		@(negedge core_clk);
		chk("request", 32'h0, {31'h0, bus_req_n});
		@(negedge core_clk);
		chk("taken", 32'h0, {31'h0, bus_grant_taken_n});
		chk("req drop", 32'h1, {31'h0, bus_req_n});
		@(negedge core_clk);
		chk("owns", 32'h1, {31'h0, dma_owns});
		// Processor cycles are ignored while the bus is taken
		d0 = done_cnt;
		i_cpu.cyc(32'h10, 3'h1, 2'h0, 1'b0, 1'b0, 32'h0, rdata, ack, flt,
			av, tmo, lat);
		chk("refused", 32'h1, {31'h0, tmo});
		chk("no answer", 32'h0, done_cnt - d0);
		dma_want = 1'b0;
		repeat (2) @(negedge core_clk);
		chk("freed", 32'h1, {31'h0, bus_grant_taken_n});
		chk("not owns", 32'h0, {31'h0, dma_owns});
	endtask

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		irq_req_level = 3'h0;
		irq_use_autovec = 1'b0;
		irq_vector = 8'hA7;
		halt_req = 1'b0;
		cache_off = 1'b0;
		dma_want = 1'b0;
		repeat (3) @(negedge core_clk);
		rst = 1'b0;
		t_reset();
		t_lanes();
		t_lock();
		t_edge();
		t_iack();
		t_side();
		t_freeze();
		t_arb();
		results();
	end
endmodule
